// ### design/fpcs_defines.vh
// constants for the 100 Mb/s pcs configuration and status register
`ifndef FPCS_DEFINES_VH
`define FPCS_DEFINES_VH
`define FPCS_ADDR_W 5
`define FPCS_REG_ADDR 5'h16
`define FPCS_RESET_VAL 16'h0100
`define FPCS_RW_MASK 16'h0FA4
`define FPCS_BIT_FREE_CLK 11
`define FPCS_BIT_TQ 10
`define FPCS_BIT_SDF 9
`define FPCS_BIT_HOLD 8
`define FPCS_BIT_DESC 7
`define FPCS_BIT_F100 5
`define FPCS_BIT_NRZI 2
`define FPCS_TMO_SHORT_NS 722000
`define FPCS_TMO_LONG_NS 2000000
`define FPCS_CLK_NS 8
`define FPCS_CNT_W 18
`endif

// ### design/fpcs_sync2.v
// two flip-flop synchroniser for a level from outside the clock domain
`timescale 1ns/1ps
`default_nettype none
module fpcs_sync2 (
  input wire clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire ce, // clock enable
  input wire d, // asynchronous level
  output reg q // synchronised level
);
  reg meta_r;
  // first stage read only by the second
  always @(posedge clk) begin
    if (!rst_n) begin
      meta_r <= 1'b0;
      q <= 1'b0;
    end else if (ce) begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule
`default_nettype wire

// ### design/fpcs_lock_timer.v
// descrambler lock timeout counter, restarted by each idle or data sign of life
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defines.vh"
module fpcs_lock_timer #(
  parameter SHORT_CYC = 90250, // 722 us at 8 ns
  parameter LONG_CYC = 250000 // 2 ms at 8 ns
) (
  input wire clk, // core clock
  input wire rst_n, // synchronous reset, active low
  input wire ce, // clock enable
  input wire long_sel, // 1 selects the long timeout
  input wire restart, // descrambler saw valid symbols
  output reg expired // timeout reached, level
);
  reg [`FPCS_CNT_W-1:0] cnt_r;
  wire [`FPCS_CNT_W-1:0] limit = long_sel ? LONG_CYC[`FPCS_CNT_W-1:0]
                                            : SHORT_CYC[`FPCS_CNT_W-1:0];
  // count up until the selected limit
  always @(posedge clk) begin
    if (!rst_n) begin
      cnt_r <= {`FPCS_CNT_W{1'b0}};
      expired <= 1'b0;
    end else if (ce) begin
      if (restart) begin
        cnt_r <= {`FPCS_CNT_W{1'b0}};
        expired <= 1'b0;
      end else if (cnt_r >= limit - 1'b1) begin
        expired <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end
endmodule
`default_nettype wire

// ### design/fpcs_reg.v
// 100 Mb/s pcs configuration and status register with link qualification
// How it works
// - bits 15:12 read zero, writes to them are dropped.
// - bit 10 selects true quiet transmit mode when set.
// - bit 9 forces signal detect to detected when set.
// - link rises only after valid signal level and descrambler lock.
// - hold option 1 keeps link while signal valid, ignoring lock loss.
// - hold option 0 drops link on signal loss or lock loss.
// - bit 7 selects descrambler timeout 722 us (0) or 2 ms (1).
// - bit 5 forces the 100 Mb/s link good when set.
// - bit 2 bypasses nrzi encode and decode when set.
//
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
`include "fpcs_defines.vh"
module fpcs_reg #(
  parameter SHORT_CYC = (`FPCS_TMO_SHORT_NS) / (`FPCS_CLK_NS), // least time rounds down ok
  parameter LONG_CYC = (`FPCS_TMO_LONG_NS) / (`FPCS_CLK_NS) // exact multiple
) (
  input wire clk, // core clock, 125 MHz
  input wire rst_n, // synchronous reset, active low
  input wire ce, // clock enable, freezes state when low
  input wire [`FPCS_ADDR_W-1:0] addr, // register address
  input wire [15:0] wdata, // write data
  input wire wr_en, // write strobe
  input wire rd_en, // read strobe
  output reg [15:0] rdata, // read data, cycle after rd_en
  input wire sig_level_ok, // pma signal level valid, from pin domain
  input wire desc_lock, // descrambler locked, from pin domain
  input wire desc_alive, // descrambler saw valid symbols, same domain
  output wire true_quiet_enable, // true quiet transmit mode
  output wire force_signal_detect, // forced signal detect to pma
  output wire signal_detect, // effective signal detect
  output wire descrambler_timeout_sel, // 1 = long timeout
  output wire desc_timeout, // descrambler timeout expired
  output wire nrzi_bypass, // bypass nrzi coding
  output wire free_clk, // stored receive clock control
  output wire link_100_ok // qualified 100 Mb/s link
);
  reg [15:0] cfg_r;
  reg link_r;
  reg link_nxt;
  wire sig_s;
  wire lock_s;
  wire lock_ok;

  // address decode shared by read and write
  function hit;
    input [`FPCS_ADDR_W-1:0] a;
    begin
      hit = (a == `FPCS_REG_ADDR);
    end
  endfunction

  fpcs_sync2 u_sync_sig (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(sig_level_ok),
    .q(sig_s)
  );

  fpcs_sync2 u_sync_lock (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .d(desc_lock),
    .q(lock_s)
  );

  fpcs_lock_timer #(
    .SHORT_CYC(SHORT_CYC),
    .LONG_CYC(LONG_CYC)
  ) u_timer (
    .clk(clk),
    .rst_n(rst_n),
    .ce(ce),
    .long_sel(cfg_r[`FPCS_BIT_DESC]),
    .restart(desc_alive),
    .expired(desc_timeout)
  );

  always @(posedge clk) begin
    if (!rst_n) begin
      cfg_r <= `FPCS_RESET_VAL;
    end else if (ce && wr_en && hit(addr)) begin
      cfg_r <= wdata & `FPCS_RW_MASK;
    end
  end

  // read data registered, zero for other addresses
  always @(posedge clk) begin
    if (!rst_n) begin
      rdata <= 16'h0000;
    end else if (ce) begin
      if (rd_en && hit(addr)) begin
        rdata <= cfg_r;
      end else begin
        rdata <= 16'h0000;
      end
    end
  end

  assign true_quiet_enable = cfg_r[`FPCS_BIT_TQ];
  assign force_signal_detect = cfg_r[`FPCS_BIT_SDF];
  assign signal_detect = sig_s | cfg_r[`FPCS_BIT_SDF];
  assign descrambler_timeout_sel = cfg_r[`FPCS_BIT_DESC];
  assign nrzi_bypass = cfg_r[`FPCS_BIT_NRZI];
  assign free_clk = cfg_r[`FPCS_BIT_FREE_CLK];
  assign lock_ok = lock_s & ~desc_timeout;

  // link qualification
  always @* begin
    link_nxt = link_r;
    if (!link_r) begin
      link_nxt = signal_detect & lock_ok;
    end else if (cfg_r[`FPCS_BIT_HOLD]) begin
      link_nxt = signal_detect;
    end else begin
      link_nxt = signal_detect & lock_ok;
    end
  end

  always @(posedge clk) begin
    if (!rst_n) begin
      link_r <= 1'b0;
    end else if (ce) begin
      link_r <= link_nxt;
    end
  end

  assign link_100_ok = link_r | cfg_r[`FPCS_BIT_F100];
endmodule
`default_nettype wire

// ### test/fpcs_reg_chk.sv
// assertions on the pcs configuration register ports
`timescale 1ns/1ps
`default_nettype none
module fpcs_reg_chk (
  input wire logic clk, // clock
  input wire logic rst_n, // reset
  input wire logic ce, // enable
  input wire logic [4:0] addr, // address
  input wire logic [15:0] wdata, // data
  input wire logic wr_en, // write
  input wire logic rd_en, // read
  input wire logic [15:0] rdata, // read data
  input wire logic true_quiet_enable, // quiet
  input wire logic force_signal_detect, // force
  input wire logic signal_detect, // detect
  input wire logic nrzi_bypass // bypass
);
  // a write that lands in the register
  wire hit = ce && wr_en && addr == 5'h16;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  chk_rsvd_zero: assert property ((rdata&16'hF05B)==0) else $error("reserved set");
  chk_rd_idle: assert property (ce && !rd_en |=> rdata==0) else $error("stray data");
  chk_rd_other: assert property (rd_en && addr!=5'h16 |=> rdata==0) else $error("bad addr");
  chk_tq_wr: assert property (hit |=> true_quiet_enable==$past(wdata[10])) else $error("quiet");
  chk_tq_hold: assert property (!hit |=> $stable(true_quiet_enable)) else $error("quiet moved");
  chk_sdf_wr: assert property (hit |=> force_signal_detect==$past(wdata[9])) else $error("force");
  chk_sd_forced: assert property (force_signal_detect |-> signal_detect) else $error("detect");
  chk_nrzi_wr: assert property (hit |=> nrzi_bypass==$past(wdata[2])) else $error("bypass");
  cover property (hit);
  cover property (rd_en ##1 rdata!=0);
  cover property ($rose(signal_detect));
endmodule
bind fpcs_reg fpcs_reg_chk u_chk (.*);
`default_nettype wire

// ### test/tb_fpcs_reg.sv
// bench for the pcs configuration register
`timescale 1ns/1ps
`default_nettype none
`define CK(a,b) begin cmp_count++; if((a)!==(b)) begin error_cnt++; $display("ERROR %0t %h %h",$time,a,b); end end
module tb_fpcs_reg;
  logic clk=0, rst_n=0, ce=1, wr_en=0, rd_en=0, sig_level_ok=0, desc_lock=0, desc_alive=1;
  logic [4:0] addr=0;
  logic [15:0] wdata=0;
  wire [15:0] rdata;
  wire true_quiet_enable, force_signal_detect, signal_detect, descrambler_timeout_sel;
  wire desc_timeout, nrzi_bypass, free_clk, link_100_ok;
  int error_cnt=0, cmp_count=0;
  // timeouts shortened to 20 and 50 cycles
  fpcs_reg #(.SHORT_CYC(20), .LONG_CYC(50)) dut (.*);
  always #4 clk=~clk;
  task automatic wr(input logic [15:0] d);
    @(posedge clk);
    addr<=5'h16;
    wdata<=d;
    wr_en<=1;
    @(posedge clk);
    wr_en<=0;
    #1;
  endtask
  task automatic rd(input logic [4:0] a, input logic [15:0] e);
    @(posedge clk);
    addr<=a;
    rd_en<=1;
    @(posedge clk);
    rd_en<=0;
    #1 `CK(rdata,e)
  endtask
  task automatic lk(input int n, input logic e);
    repeat(n) @(posedge clk);
    #1 `CK(link_100_ok,e)
  endtask
  task automatic t_regs;
    rd(5'h16,16'h0100);
    wr(16'hFFFF);
    `CK({free_clk,true_quiet_enable,force_signal_detect,signal_detect},4'hF)
    `CK({descrambler_timeout_sel,nrzi_bypass},2'h3)
    rd(5'h16,16'h0FA4);
    rd(5'h15,16'h0);
    wr(16'h0);
    `CK({true_quiet_enable,signal_detect,nrzi_bypass},3'h0)
    // a write while the clock enable is low must leave the register alone
    @(posedge clk) ce<=0;
    wr(16'h0400);
    `CK(true_quiet_enable,1'b0)
    @(posedge clk) ce<=1;
    $display("t_regs end");
  endtask
  task automatic t_link;
    wr(16'h0100);
    @(posedge clk) sig_level_ok<=1;
    lk(5,0);
    @(posedge clk) desc_lock<=1;
    lk(4,1);
    @(posedge clk) desc_lock<=0;
    lk(4,1);
    wr(16'h0);
    lk(2,0);
    wr(16'h20);
    lk(0,1);
    $display("t_link end");
  endtask
  task automatic t_tmo;
    wr(16'h0);
    @(posedge clk) desc_lock<=1;
    lk(4,1);
    @(posedge clk) desc_alive<=0;
    lk(30,0);
    `CK(desc_timeout,1'b1)
    wr(16'h80);
    @(posedge clk) desc_alive<=1;
    @(posedge clk) desc_alive<=0;
    lk(30,1);
    `CK(desc_timeout,1'b0)
    $display("t_tmo end");
  endtask
  task automatic report_and_stop;
    $display("compares %0d errors %0d",cmp_count,error_cnt);
    if (error_cnt==0 && cmp_count>0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // reset for two cycles, then the scenarios
  initial begin
    repeat(2) @(posedge clk);
    rst_n<=1;
    t_regs;
    t_link;
    t_tmo;
    report_and_stop;
  end
  // watchdog against a hang
  initial begin
    #100000;
    error_cnt++;
    report_and_stop;
  end
endmodule
`default_nettype wire
